// File: design/mode_select_pkg.sv
// Constants and types for the direct setpoint mode selection block
package mode_select_pkg;
  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DIGIT1_LSB = 4;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_TRACK_BIT = 7;
  localparam int unsigned CTRL_REARM_BIT = 0;
  localparam int unsigned MODE_JOG = 0;
  localparam int unsigned MODE_HOME = 1;
  localparam int unsigned MODE_BLOCKS = 2;
  localparam int unsigned MODE_DIR_POS = 3;
  localparam int unsigned MODE_DIR_SETUP = 4;
  localparam int unsigned MODE_PASSIVE = 5;
  localparam int unsigned MODE_W = 32;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [3:0] DIG_ABS = 4'h0;
  localparam logic [3:0] DIG_REL = 4'h1;
  localparam logic [3:0] DIG_ABS_POS = 4'h2;
  localparam logic [3:0] DIG_ABS_NEG = 4'h3;
  localparam logic [63:0] POS_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] VEL_RST = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    POS_ABS = 2'b00,
    POS_REL = 2'b01,
    POS_ABS_POSDIR = 2'b10,
    POS_ABS_NEGDIR = 2'b11
  } pos_kind_t;

  typedef enum logic [1:0] {
    DIR_STILL = 2'b00,
    DIR_POS = 2'b01,
    DIR_NEG = 2'b10,
    DIR_SHORT = 2'b11
  } dir_t;

  // Setpoints handed downstream
  typedef struct packed {
    logic [63:0] pos;
    logic [31:0] vel;
  } setpoint_t;

  // Decoded direct setpoint selection
  typedef struct packed {
    logic setup;
    pos_kind_t kind;
    dir_t dir;
    logic invalid;
  } sel_t;
endpackage : mode_select_pkg

// File: design/mode_decode.sv
// Combinational decode of positioning type and direction
`timescale 1ns/1ps
`default_nettype none
module mode_decode
  import mode_select_pkg::*;
(
  // Raw selection
  input wire logic setup_sel,
  input wire logic [WORD_W-1:0] word,
  input wire logic pos_type_sel,
  input wire logic dir_p,
  input wire logic dir_n,
  input wire logic modulo_en,
  // Decoded result
  output sel_t sel
);
  logic [3:0] digit;

  assign digit = word[DIGIT1_LSB +: 4];

  // Pick word or discrete inputs and decode
  always_comb begin
    sel = '{setup: setup_sel, kind: POS_ABS, dir: DIR_STILL, invalid: 1'b0};
    if (word != WORD_RST) begin
      case (digit)
        DIG_ABS: sel.kind = POS_ABS;
        DIG_REL: sel.kind = POS_REL;
        DIG_ABS_POS: begin
          sel.kind = POS_ABS_POSDIR;
          sel.invalid = !modulo_en;
        end
        DIG_ABS_NEG: begin
          sel.kind = POS_ABS_NEGDIR;
          sel.invalid = !modulo_en;
        end
        default: sel.invalid = 1'b1;
      endcase
      sel.dir = (sel.kind == POS_ABS_POSDIR) ? DIR_POS :
                (sel.kind == POS_ABS_NEGDIR) ? DIR_NEG : DIR_SHORT;
    end else begin
      sel.kind = pos_type_sel ? POS_ABS : POS_REL;
      if (setup_sel) begin
        sel.dir = (dir_p == dir_n) ? DIR_STILL : (dir_p ? DIR_POS : DIR_NEG);
      end else if (pos_type_sel && modulo_en && (dir_p != dir_n)) begin
        sel.dir = dir_p ? DIR_POS : DIR_NEG;
      end else begin
        sel.dir = DIR_SHORT;
      end
    end
    if (word != WORD_RST && setup_sel) begin
      sel.dir = DIR_STILL;
    end
  end
endmodule : mode_decode
`default_nettype wire

// File: design/positioner_mode_select.sv
// Top of the direct setpoint mode selection and status block
`timescale 1ns/1ps
`default_nettype none
module positioner_mode_select
  import mode_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Direct setpoint selection
  input wire logic direct_mode_in,
  input wire logic setup_select_in,
  input wire logic [WORD_W-1:0] mode_adapt_word_in,
  input wire logic pos_type_select_in,
  input wire logic dir_positive_select_in,
  input wire logic dir_negative_select_in,
  input wire logic modulo_en_in,
  // Other mode activity from the sequencer
  input wire logic jog_active_in,
  input wire logic home_active_in,
  input wire logic blocks_active_in,
  input wire logic passive_home_in,
  // Tracking control
  input wire logic [1:0] tracking_select_in,
  input wire logic tracking_use_default_in,
  input wire logic [CTRL_W-1:0] positioner_ctrl_status,
  input wire logic fault_in,
  input wire logic enable_in,
  // Setpoints from the generator
  input wire setpoint_t gen_setpoint_in,
  // Setpoint outputs
  output setpoint_t pos_vel_out,
  output logic [63:0] pos_setpoint_out,
  output logic [31:0] vel_setpoint_out,
  output logic [63:0] pos_setpoint_sink,
  output logic [31:0] vel_setpoint_sink,
  // Decoded selection and status
  output sel_t sel_out,
  output logic tracking_out,
  output logic [MODE_W-1:0] active_mode_status
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  sel_t dec;
  logic [1:0] trk_sel;
  logic runup_r;
  logic runup_nxt;
  logic rearm_d_r;
  logic rearm_d_nxt;
  logic trk_force_r;
  logic trk_force_nxt;
  logic tracking_r;
  logic tracking_nxt;
  logic en_d_r;
  logic en_d_nxt;
  sel_t sel_r;
  sel_t sel_nxt;
  setpoint_t sp_r;
  setpoint_t sp_nxt;
  logic [MODE_W-1:0] mode_r;
  logic [MODE_W-1:0] mode_nxt;

  mode_decode u_dec (
    .setup_sel(setup_select_in),
    .word(mode_adapt_word_in),
    .pos_type_sel(pos_type_select_in),
    .dir_p(dir_positive_select_in),
    .dir_n(dir_negative_select_in),
    .modulo_en(modulo_en_in),
    .sel(dec)
  );

  // Default tracking sources or external selects
  always_comb begin
    if (tracking_use_default_in) begin
      trk_sel = {positioner_ctrl_status[CTRL_TRACK_BIT], 1'b1};
    end else begin
      trk_sel = tracking_select_in;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Selection, tracking and status updated every cycle
  always_comb begin
    sel_nxt = dec;
    runup_nxt = 1'b0;
    rearm_d_nxt = positioner_ctrl_status[CTRL_REARM_BIT];
    en_d_nxt = enable_in;
    // Forced tracking on run-up, rising control bit 0 or fault
    trk_force_nxt = runup_r || fault_in ||
      (positioner_ctrl_status[CTRL_REARM_BIT] && !rearm_d_r);
    tracking_nxt = tracking_r;
    if (en_d_r && !enable_in) begin
      tracking_nxt = (|trk_sel) || trk_force_nxt;
    end else if (enable_in) begin
      tracking_nxt = 1'b0;
    end
    if (trk_force_nxt && !enable_in) begin
      tracking_nxt = 1'b1;
    end
    sp_nxt = gen_setpoint_in;
    mode_nxt = MODE_RST;
    if (jog_active_in) begin
      mode_nxt[MODE_JOG] = 1'b1;
    end else if (home_active_in) begin
      mode_nxt[MODE_HOME] = 1'b1;
    end else if (blocks_active_in) begin
      mode_nxt[MODE_BLOCKS] = 1'b1;
    end else if (direct_mode_in) begin
      mode_nxt[MODE_DIR_SETUP] = dec.setup;
      mode_nxt[MODE_DIR_POS] = !dec.setup;
    end
    mode_nxt[MODE_PASSIVE] = passive_home_in;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      runup_r <= 1'b1;
      rearm_d_r <= 1'b0;
      en_d_r <= 1'b0;
      trk_force_r <= 1'b1;
      tracking_r <= 1'b1;
      sel_r <= '{setup: 1'b0, kind: POS_ABS, dir: DIR_STILL, invalid: 1'b0};
      sp_r <= '{pos: POS_RST, vel: VEL_RST};
      mode_r <= MODE_RST;
    end else begin
      runup_r <= runup_nxt;
      rearm_d_r <= rearm_d_nxt;
      en_d_r <= en_d_nxt;
      trk_force_r <= trk_force_nxt;
      tracking_r <= tracking_nxt;
      sel_r <= sel_nxt;
      sp_r <= sp_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign sel_out = sel_r;
  assign tracking_out = tracking_r;
  assign pos_vel_out = sp_r;
  assign pos_setpoint_out = sp_r.pos;
  assign vel_setpoint_out = sp_r.vel;
  assign pos_setpoint_sink = sp_r.pos;
  assign vel_setpoint_sink = sp_r.vel;
  assign active_mode_status = mode_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_enable_drop;
    en_d_r && !enable_in;
  endsequence

  property p_setup_follows;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (sel_r.setup == $past(setup_select_in));
  endproperty
  a_setup_follows: assert property (p_setup_follows)
    else $error("setup select not followed");

  property p_flying_change;
    @(posedge clk_sys) disable iff (rst)
      (direct_mode_in && !jog_active_in && !home_active_in && !blocks_active_in
        && enable_in && setup_select_in && !$past(setup_select_in))
      |=> active_mode_status[MODE_DIR_SETUP];
  endproperty
  a_flying_change: assert property (p_flying_change)
    else $error("flying change to setting-up missed");

  property p_word_override;
    @(posedge clk_sys) disable iff (rst)
      (mode_adapt_word_in[7:4] == DIG_REL && mode_adapt_word_in != WORD_RST
        && pos_type_select_in) |=> (sel_r.kind == POS_REL);
  endproperty
  a_word_override: assert property (p_word_override)
    else $error("nonzero word did not override type input");

  property p_discrete_type;
    @(posedge clk_sys) disable iff (rst)
      (mode_adapt_word_in == WORD_RST) |=>
        (sel_r.kind == ($past(pos_type_select_in) ? POS_ABS : POS_REL));
  endproperty
  a_discrete_type: assert property (p_discrete_type)
    else $error("discrete positioning type wrong");

  property p_setup_still;
    @(posedge clk_sys) disable iff (rst)
      (setup_select_in && mode_adapt_word_in == WORD_RST
        && dir_positive_select_in == dir_negative_select_in) |=> (sel_r.dir == DIR_STILL);
  endproperty
  a_setup_still: assert property (p_setup_still)
    else $error("axis not held still in setting-up");

  property p_track_select;
    @(posedge clk_sys) disable iff (rst)
      (s_enable_drop and (|trk_sel)) |=> tracking_out;
  endproperty
  a_track_select: assert property (p_track_select)
    else $error("tracking not selected after enable drop");

  property p_fault_track;
    @(posedge clk_sys) disable iff (rst)
      (fault_in && !enable_in) [*2] |=> tracking_out;
  endproperty
  a_fault_track: assert property (p_fault_track)
    else $error("fault did not force tracking");

  // Registered force request must show as tracking while enable was low
  property p_force_track;
    @(posedge clk_sys) disable iff (rst)
      (trk_force_r && !$past(enable_in)) |-> tracking_out;
  endproperty
  a_force_track: assert property (p_force_track)
    else $error("forced tracking not applied");

  property p_one_mode;
    @(posedge clk_sys) disable iff (rst)
      $onehot0(active_mode_status[MODE_DIR_SETUP:MODE_JOG]);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("more than one mode bit set");

  property p_setpoint_pass;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (pos_setpoint_sink == $past(gen_setpoint_in.pos)
        && vel_setpoint_sink == $past(gen_setpoint_in.vel));
  endproperty
  a_setpoint_pass: assert property (p_setpoint_pass)
    else $error("setpoint not passed downstream");
endmodule : positioner_mode_select
`default_nettype wire

// File: tb/setpoint_gen_model.sv
// Setpoint generator model feeding the mode select block
`timescale 1ns/1ps
`default_nettype none
module setpoint_gen_model
  import mode_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Setpoint stream
  output var setpoint_t sp
);
  logic [31:0] cnt_r;
  // New pattern every cycle so a stale copy shows up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0000_0001;
    end else begin
      cnt_r <= cnt_r * 32'h0000_0003 + 32'h0000_0007;
    end
  end
  assign sp = '{pos: {cnt_r, ~cnt_r}, vel: cnt_r ^ 32'h5a5a_5a5a};
endmodule : setpoint_gen_model
`default_nettype wire

// File: tb/positioner_mode_select_tb_top.sv
// Self-checking bench for the mode select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s exp %h got %h", nm, ex, got); end end
module positioner_mode_select_tb_top;
  import mode_select_pkg::*;
  typedef struct packed {
    logic s;
    logic [15:0] w;
    logic pt, dp, dn, mo;
    logic [5:0] e, m, st;
  } row_t;
  logic clk_sys = 0, rst = 1, dm = 1, su = 0, pt = 0, dp = 0, dn = 0, mo = 0;
  logic jog = 0, hom = 0, blk = 0, pas = 0, usedef = 0, flt = 0, en = 0;
  logic [15:0] w = 16'h0000, ctrl = 16'h0000;
  logic [1:0] tsel = 2'b00;
  setpoint_t gen, gen_q, pv;
  sel_t sel;
  logic trk;
  logic [63:0] pos_o, pos_k;
  logic [31:0] vel_o, vel_k, mst;
  int fails = 0, check_count = 0;
  // Ordinary selections: setup, word, type, dirs, modulo, sel, mask, status
  row_t rows[16] = '{
    '{1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 6'h39, 6'h08},
    '{1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 6'h08, 6'h39, 6'h08},
    '{1'b0, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b1, 6'h02, 6'h3f, 6'h08},
    '{1'b0, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b1, 6'h04, 6'h3f, 6'h08},
    '{1'b0, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 6'h06, 6'h3f, 6'h08},
    '{1'b0, 16'h0010, 1'b1, 1'b1, 1'b0, 1'b1, 6'h0e, 6'h3f, 6'h08},
    '{1'b0, 16'h0020, 1'b0, 1'b0, 1'b1, 1'b1, 6'h12, 6'h3f, 6'h08},
    '{1'b0, 16'h0030, 1'b0, 1'b1, 1'b0, 1'b1, 6'h1c, 6'h3f, 6'h08},
    '{1'b0, 16'h0100, 1'b0, 1'b1, 1'b0, 1'b1, 6'h06, 6'h3f, 6'h08},
    '{1'b0, 16'h0020, 1'b0, 1'b0, 1'b0, 1'b0, 6'h11, 6'h39, 6'h08},
    '{1'b0, 16'h0050, 1'b0, 1'b0, 1'b0, 1'b1, 6'h07, 6'h3f, 6'h08},
    '{1'b1, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 6'h22, 6'h27, 6'h10},
    '{1'b1, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0, 6'h24, 6'h27, 6'h10},
    '{1'b1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 6'h20, 6'h27, 6'h10},
    '{1'b1, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 6'h20, 6'h27, 6'h10},
    '{1'b1, 16'h0010, 1'b0, 1'b1, 1'b0, 1'b0, 6'h20, 6'h27, 6'h10}};
  // --------------------------------
  // Design and partner
  // --------------------------------
  setpoint_gen_model setpoint_gen_model_inst (.clk_sys(clk_sys), .rst(rst), .sp(gen));
  positioner_mode_select positioner_mode_select_inst (.clk_sys(clk_sys), .rst(rst),
    .direct_mode_in(dm), .setup_select_in(su), .mode_adapt_word_in(w),
    .pos_type_select_in(pt), .dir_positive_select_in(dp), .dir_negative_select_in(dn),
    .modulo_en_in(mo), .jog_active_in(jog), .home_active_in(hom), .blocks_active_in(blk),
    .passive_home_in(pas), .tracking_select_in(tsel), .tracking_use_default_in(usedef),
    .positioner_ctrl_status(ctrl), .fault_in(flt), .enable_in(en),
    .gen_setpoint_in(gen), .pos_vel_out(pv), .pos_setpoint_out(pos_o),
    .vel_setpoint_out(vel_o), .pos_setpoint_sink(pos_k), .vel_setpoint_sink(vel_k),
    .sel_out(sel), .tracking_out(trk), .active_mode_status(mst));
  // Clock and one-cycle copy of the generator
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) gen_q <= gen;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #8000;
    fails++;
    print_verdict();
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    tick(10);
    `CHK("trk_rst", 1'b1, trk)
    `CHK("pos_rst", POS_RST, pos_o)
    `CHK("mode_rst", MODE_RST, mst)
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    `CHK("trk_runup", 1'b1, trk)
    foreach (rows[i]) begin
      @(posedge clk_sys);
      {su, w, pt, dp, dn, mo} <= {rows[i].s, rows[i].w, rows[i].pt, rows[i].dp, rows[i].dn,
        rows[i].mo};
      tick(1);
      `CHK("sel", rows[i].e & rows[i].m, sel & rows[i].m)
      `CHK("mode", {26'h0, rows[i].st}, mst)
      `CHK("pos", gen_q.pos, pos_o)
      `CHK("vel", gen_q.vel, vel_o)
      `CHK("sink", {gen_q.pos, gen_q.vel}, {pos_k, vel_k})
      `CHK("pv", gen_q, pv)
    end
    // Jog, homing and blocks outrank the direct modes; passive homing sets its bit alongside them
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {su, w} <= 17'h0;
      {pas, blk, hom, jog} <= 4'(1 << i);
      tick(2);
      `CHK("prio", (i < 3) ? 32'(1 << i) : 32'h0000_0028, mst)
    end
    // No mode at all without direct mode or other activity
    @(posedge clk_sys);
    {pas, blk, hom, jog} <= 4'h0;
    dm <= 1'b0;
    tick(1);
    `CHK("mode_off", MODE_RST, mst)
    @(posedge clk_sys);
    dm <= 1'b1;
    // Tracking after enable withdrawal: select, default wiring, fault
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      en <= 1'b1;
      tsel <= (i < 3) ? 2'(i) : 2'b00;
      usedef <= (i == 3);
      tick(3);
      `CHK("trk_en", 1'b0, trk)
      @(posedge clk_sys);
      en <= 1'b0;
      flt <= (i == 4);
      tick(2);
      `CHK("trk", i != 0, trk)
    end
    // Enable clears tracking; a rising control bit 0 forces it, its level does not
    @(posedge clk_sys);
    flt <= 1'b0;
    en <= 1'b1;
    tick(2);
    `CHK("trk_off", 1'b0, trk)
    @(posedge clk_sys);
    en <= 1'b0;
    tick(2);
    `CHK("trk_idle", 1'b0, trk)
    @(posedge clk_sys);
    ctrl <= 16'h0001;
    tick(2);
    `CHK("trk_rise", 1'b1, trk)
    @(posedge clk_sys);
    en <= 1'b1;
    tick(2);
    `CHK("trk_clear", 1'b0, trk)
    @(posedge clk_sys);
    en <= 1'b0;
    tick(2);
    `CHK("trk_level", 1'b0, trk)
    // Flying change from positioning to setting-up while enabled
    @(posedge clk_sys);
    en <= 1'b1;
    su <= 1'b0;
    w <= 16'h0000;
    tick(1);
    `CHK("fly_pos", 32'h0000_0008, mst)
    @(posedge clk_sys);
    su <= 1'b1;
    tick(1);
    `CHK("fly_setup", 32'h0000_0010, mst)
    // Second reset in mid-run: status clears, run-up forces tracking
    @(posedge clk_sys);
    rst <= 1'b1;
    en <= 1'b0;
    tick(2);
    `CHK("mode_rst2", MODE_RST, mst)
    @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    `CHK("trk_runup2", 1'b1, trk)
    print_verdict();
  end
endmodule : positioner_mode_select_tb_top
`default_nettype wire
